// ===== inc/led_cfg_pkg.sv
// constants for the segment, scan and low-grayscale configuration register
package led_cfg_pkg;
  localparam int REG_WIDTH = 48;
  localparam int ADDR_WIDTH = 4;
  localparam int DATA_WIDTH = 16;
  // word offsets of the 48-bit register, low word first, then the multiplier and the two derived read words
  localparam logic [3:0] ADDR_WORD0 = 4'h0;
  localparam logic [3:0] ADDR_WORD1 = 4'h1;
  localparam logic [3:0] ADDR_WORD2 = 4'h2;
  localparam logic [3:0] ADDR_MULT = 4'h3;
  localparam logic [3:0] ADDR_DERIVED0 = 4'h4;
  localparam logic [3:0] ADDR_DERIVED1 = 4'h5;
  // field positions
  localparam int SEG_LSB = 0;
  localparam int SEG_W = 10;
  localparam int RSTEP_LSB = 10;
  localparam int GSTEP_LSB = 15;
  localparam int BSTEP_LSB = 20;
  localparam int STEP_W = 5;
  localparam int RBOOST_LSB = 25;
  localparam int GBOOST_LSB = 29;
  localparam int BBOOST_LSB = 33;
  localparam int BOOST_W = 4;
  localparam int ROW_LSB = 37;
  localparam int ROW_W = 4;
  localparam int TRIM_LSB = 41;
  localparam int TRIM_W = 6;
  localparam int RSVD_BIT = 47;
  localparam int MULT_W = 4;
  // reset values
  localparam logic [47:0] REG_RESET = 48'h00e0_0094_a400;
  localparam logic [47:0] REG_WMASK = 48'h7fff_ffff_ffff;
  localparam logic [3:0] MULT_RESET = 4'h7;
  // decoding constants
  localparam logic [10:0] SEG_MIN_CODE = 11'h07f;
  localparam logic [10:0] SEG_DEFAULT = 11'h080;
  localparam logic [10:0] ROW_ZERO_CLOCKS = 11'h02d;
  localparam logic [10:0] ROW_UNIT_CLOCKS = 11'h01e;
endpackage

// ===== hdl/led_matrix_timing_config_reg.sv
// configuration register for segment length, row switch and low-grayscale tuning
//
// What this block does
// - segment clock count: codes 127..1023 give code+1 clocks, else 128
// - three 5-bit smoothing steps reset to 01001b, code n means level n+1
// - three 4-bit dim boost fields reset to zero, code n means level n
// - row switch: code zero gives 45 clocks, else (n+1)*30 clocks
// - row switch field resets to 0111b, giving 8x30 clocks
// - black field trim adds n clocks, 0 to 63, resets to zero
// - grayscale clock multiplier code n gives n+1 times serial clock
`timescale 1ns/100ps
module led_matrix_timing_config_reg (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [led_cfg_pkg::ADDR_WIDTH-1:0] regAddr,
  input wire logic [led_cfg_pkg::DATA_WIDTH-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [led_cfg_pkg::DATA_WIDTH-1:0] regRdData,
  // raw fields
  output logic [9:0] segment_clock_count,
  output logic [4:0] red_smooth_step,
  output logic [4:0] green_smooth_step,
  output logic [4:0] blue_smooth_step,
  output logic [3:0] red_dim_boost,
  output logic [3:0] green_dim_boost,
  output logic [3:0] blue_dim_boost,
  output logic [3:0] row_switch_interval,
  output logic [5:0] black_field_trim,
  output logic [3:0] grayscale_clock_multiplier,
  // decoded values for the pwm and scan logic
  output logic [10:0] segmentClocks,
  output logic [5:0] redStepLevel,
  output logic [5:0] greenStepLevel,
  output logic [5:0] blueStepLevel,
  output logic [10:0] rowSwitchClocks,
  output logic [4:0] clockMultiple
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [47:0] cfg;
  logic [47:0] next_cfg;
  logic [3:0] mult;
  logic [3:0] next_mult;
  logic [15:0] next_regRdData;
  logic [47:0] wordMask;
  logic [47:0] wordData;

  always_comb begin
    next_cfg = cfg;
    next_mult = mult;
    wordMask = 48'h0000_0000_0000;
    wordData = 48'h0000_0000_0000;
    if (regWrite) begin
      case (regAddr)
        led_cfg_pkg::ADDR_WORD0: begin
          wordMask = 48'h0000_0000_ffff;
          wordData = {32'h0000_0000, regWrData};
        end
        led_cfg_pkg::ADDR_WORD1: begin
          wordMask = 48'h0000_ffff_0000;
          wordData = {16'h0000, regWrData, 16'h0000};
        end
        led_cfg_pkg::ADDR_WORD2: begin
          wordMask = 48'hffff_0000_0000;
          wordData = {regWrData, 32'h0000_0000};
        end
        led_cfg_pkg::ADDR_MULT: begin
          next_mult = regWrData[led_cfg_pkg::MULT_W-1:0];
        end
        default: begin
          wordMask = 48'h0000_0000_0000;
        end
      endcase
      // bit 47 never takes a written value
      wordMask = wordMask & led_cfg_pkg::REG_WMASK;
      next_cfg = (cfg & ~wordMask) | (wordData & wordMask);
    end
  end

  // word writes land on the next edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg <= led_cfg_pkg::REG_RESET;
      mult <= led_cfg_pkg::MULT_RESET;
    end else begin
      cfg <= next_cfg;
      mult <= next_mult;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field extraction
  logic [47:0] cfgView;
  logic [3:0] multView;

  logic [9:0] fSeg;
  logic [4:0] fRStep;
  logic [4:0] fGStep;
  logic [4:0] fBStep;
  logic [3:0] fRBoost;
  logic [3:0] fGBoost;
  logic [3:0] fBBoost;
  logic [3:0] fRow;
  logic [5:0] fTrim;

  // while rst is high the reset contents feed every field and decoded output register; read data is held at zero
  assign cfgView = rst ? led_cfg_pkg::REG_RESET : cfg;
  assign multView = rst ? led_cfg_pkg::MULT_RESET : mult;

  // field slices
  assign fSeg = cfgView[led_cfg_pkg::SEG_LSB +: led_cfg_pkg::SEG_W];
  assign fRStep = cfgView[led_cfg_pkg::RSTEP_LSB +: led_cfg_pkg::STEP_W];
  assign fGStep = cfgView[led_cfg_pkg::GSTEP_LSB +: led_cfg_pkg::STEP_W];
  assign fBStep = cfgView[led_cfg_pkg::BSTEP_LSB +: led_cfg_pkg::STEP_W];
  assign fRBoost = cfgView[led_cfg_pkg::RBOOST_LSB +: led_cfg_pkg::BOOST_W];
  assign fGBoost = cfgView[led_cfg_pkg::GBOOST_LSB +: led_cfg_pkg::BOOST_W];
  assign fBBoost = cfgView[led_cfg_pkg::BBOOST_LSB +: led_cfg_pkg::BOOST_W];
  assign fRow = cfgView[led_cfg_pkg::ROW_LSB +: led_cfg_pkg::ROW_W];
  assign fTrim = cfgView[led_cfg_pkg::TRIM_LSB +: led_cfg_pkg::TRIM_W];

  ////////////////////////////////////////////////////////////////////////////
  // decoding
  logic [10:0] next_segmentClocks;
  logic [10:0] next_rowSwitchClocks;
  logic [5:0] next_redStepLevel;
  logic [5:0] next_greenStepLevel;
  logic [5:0] next_blueStepLevel;
  logic [4:0] next_clockMultiple;
  logic [10:0] rowCode;
  logic [10:0] segPlusOne;
  logic [4:0] rowPlusOne;

  // segment code plus one
  code_plus_one #(
    .W(led_cfg_pkg::SEG_W)
  ) segPlusOne_i (
    .code(fSeg),
    .level(segPlusOne)
  );

  // row switch code plus one
  code_plus_one #(
    .W(led_cfg_pkg::ROW_W)
  ) rowPlusOne_i (
    .code(fRow),
    .level(rowPlusOne)
  );

  // segment and row switch lengths
  always_comb begin
    rowCode = {6'h00, rowPlusOne};
    if ({1'b0, fSeg} >= led_cfg_pkg::SEG_MIN_CODE) begin
      next_segmentClocks = segPlusOne;
    end else begin
      next_segmentClocks = led_cfg_pkg::SEG_DEFAULT;
    end
    if (fRow == 4'h0) begin
      next_rowSwitchClocks = led_cfg_pkg::ROW_ZERO_CLOCKS;
    end else begin
      next_rowSwitchClocks = 11'(rowCode * led_cfg_pkg::ROW_UNIT_CLOCKS);
    end
  end

  // smoothing step levels
  code_plus_one #(
    .W(led_cfg_pkg::STEP_W)
  ) redStepLevel_i (
    .code(fRStep),
    .level(next_redStepLevel)
  );

  code_plus_one #(
    .W(led_cfg_pkg::STEP_W)
  ) greenStepLevel_i (
    .code(fGStep),
    .level(next_greenStepLevel)
  );

  code_plus_one #(
    .W(led_cfg_pkg::STEP_W)
  ) blueStepLevel_i (
    .code(fBStep),
    .level(next_blueStepLevel)
  );

  // clock multiple
  code_plus_one #(
    .W(led_cfg_pkg::MULT_W)
  ) clockMultiple_i (
    .code(multView),
    .level(next_clockMultiple)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path
  // read data stands in the cycle after the strobe
  always_comb begin
    next_regRdData = 16'h0000;
    if (regRead && !rst) begin
      case (regAddr)
        led_cfg_pkg::ADDR_WORD0: next_regRdData = cfg[15:0];
        led_cfg_pkg::ADDR_WORD1: next_regRdData = cfg[31:16];
        led_cfg_pkg::ADDR_WORD2: begin
          next_regRdData = cfg[47:32];
          next_regRdData[led_cfg_pkg::RSVD_BIT-32] = 1'b0;
        end
        led_cfg_pkg::ADDR_MULT: next_regRdData = {12'h000, mult};
        led_cfg_pkg::ADDR_DERIVED0: next_regRdData = {5'h00, next_segmentClocks};
        led_cfg_pkg::ADDR_DERIVED1: next_regRdData = {5'h00, next_rowSwitchClocks};
        default: next_regRdData = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // raw field registers
  logic [9:0] next_segment_clock_count;

  logic [4:0] next_red_smooth_step;
  logic [4:0] next_green_smooth_step;
  logic [4:0] next_blue_smooth_step;

  logic [3:0] next_red_dim_boost;
  logic [3:0] next_green_dim_boost;
  logic [3:0] next_blue_dim_boost;

  logic [3:0] next_row_switch_interval;
  logic [5:0] next_black_field_trim;
  logic [3:0] next_grayscale_clock_multiplier;

  // raw fields follow the register one edge later
  always_comb begin
    next_segment_clock_count = fSeg;

    next_red_smooth_step = fRStep;
    next_green_smooth_step = fGStep;
    next_blue_smooth_step = fBStep;

    next_red_dim_boost = fRBoost;
    next_green_dim_boost = fGBoost;
    next_blue_dim_boost = fBBoost;

    next_row_switch_interval = fRow;

    next_black_field_trim = fTrim;

    next_grayscale_clock_multiplier = multView;
  end

  ////////////////////////////////////////////////////////////////////////////
  // output registers
  // read data
  always_ff @(posedge mclk) begin
    regRdData <= next_regRdData;
  end

  // raw fields
  always_ff @(posedge mclk) begin
    segment_clock_count <= next_segment_clock_count;
    red_smooth_step <= next_red_smooth_step;
    green_smooth_step <= next_green_smooth_step;
    blue_smooth_step <= next_blue_smooth_step;
    red_dim_boost <= next_red_dim_boost;
    green_dim_boost <= next_green_dim_boost;
    blue_dim_boost <= next_blue_dim_boost;
    row_switch_interval <= next_row_switch_interval;
    black_field_trim <= next_black_field_trim;
    grayscale_clock_multiplier <= next_grayscale_clock_multiplier;
  end

  // decoded values
  always_ff @(posedge mclk) begin
    segmentClocks <= next_segmentClocks;
    redStepLevel <= next_redStepLevel;
    greenStepLevel <= next_greenStepLevel;
    blueStepLevel <= next_blueStepLevel;
    rowSwitchClocks <= next_rowSwitchClocks;
    clockMultiple <= next_clockMultiple;
  end

endmodule

////////////////////////////////////////////////////////////////////////////
// code plus one, shared by the step levels, lengths and clock multiple
// level is one bit wider so the top code cannot wrap
module code_plus_one #(
  parameter int W = 5
) (
  // code in
  input wire logic [W-1:0] code,
  // level out
  output logic [W:0] level
);

  localparam logic [W:0] ONE = {{W{1'b0}}, 1'b1};

  assign level = {1'b0, code} + ONE;

endmodule

// ===== tb/led_matrix_timing_config_reg_checker.sv
// port assertions for the configuration register
`timescale 1ns/100ps
module led_matrix_timing_config_reg_checker (
  // clock, reset and register port
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdData,
  // fields
  input wire logic [9:0] segment_clock_count,
  input wire logic [4:0] red_smooth_step,
  input wire logic [3:0] row_switch_interval,
  input wire logic [3:0] grayscale_clock_multiplier,
  input wire logic [10:0] segmentClocks,
  input wire logic [5:0] redStepLevel,
  input wire logic [10:0] rowSwitchClocks,
  input wire logic [4:0] clockMultiple
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_wr0;
    regWrite && regAddr == led_cfg_pkg::ADDR_WORD0;
  endsequence
  property p_seg;
    segmentClocks == (segment_clock_count >= 10'h07f ?
      {1'b0, segment_clock_count} + 11'h001 : 11'h080);
  endproperty
  property p_step;
    redStepLevel == {1'b0, red_smooth_step} + 6'h01;
  endproperty
  property p_row;
    rowSwitchClocks == (row_switch_interval == 4'h0 ? 11'h02d :
      ({7'h00, row_switch_interval} + 11'h001) * 11'h01e);
  endproperty
  property p_mult;
    clockMultiple == {1'b0, grayscale_clock_multiplier} + 5'h01;
  endproperty
  property p_rst;
    $fell(rst) |-> row_switch_interval == 4'h7 && red_smooth_step == 5'h09;
  endproperty
  property p_idle;
    !regRead |=> regRdData == 16'h0000;
  endproperty
  property p_unmap;
    regRead && regAddr > 4'h5 |=> regRdData == 16'h0000;
  endproperty
  property p_wr0;
    s_wr0 |=> ##1 segment_clock_count == 10'($past(regWrData, 2));
  endproperty
  a_seg: assert property (p_seg) else $error("bad segment clocks");
  a_step: assert property (p_step) else $error("bad step level");
  a_row: assert property (p_row) else $error("bad row clocks");
  a_mult: assert property (p_mult) else $error("bad multiple");
  a_rst: assert property (p_rst) else $error("bad reset value");
  a_idle: assert property (p_idle) else $error("read data not idle");
  a_unmap: assert property (p_unmap) else $error("unmapped read data");
  a_wr0: assert property (p_wr0) else $error("write not applied");
endmodule
bind led_matrix_timing_config_reg led_matrix_timing_config_reg_checker
  led_matrix_timing_config_reg_checker_i (.mclk, .rst, .regAddr, .regWrData,
  .regWrite, .regRead, .regRdData, .segment_clock_count, .red_smooth_step,
  .row_switch_interval, .grayscale_clock_multiplier, .segmentClocks,
  .redStepLevel, .rowSwitchClocks, .clockMultiple);

// ===== tb/led_cfg_host.sv
// host model writing and reading configuration words
`timescale 1ns/100ps
module led_cfg_host (
  // clock
  input wire logic mclk,
  // register port
  output logic [3:0] regAddr,
  output logic [15:0] regWrData,
  output logic regWrite,
  output logic regRead,
  input wire logic [15:0] regRdData
);
  initial begin
    regAddr = 4'h0;
    regWrData = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
    regWrData <= ~v;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 v = regRdData;
  endtask
endmodule

// ===== tb/led_matrix_timing_config_reg_bench.sv
// self-checking bench for the configuration register
`timescale 1ns/100ps
module led_matrix_timing_config_reg_bench;
  typedef struct {logic [15:0] w0; logic [15:0] w2; logic [10:0] seg; logic [10:0] row;} row_t;
  row_t rows [5] = '{'{16'h0000, 16'h0000, 11'h080, 11'h02d},
    '{16'h807e, 16'h0020, 11'h080, 11'h03c}, '{16'hfc7f, 16'hfee0, 11'h080, 11'h0f0},
    '{16'h03ff, 16'h81ff, 11'h400, 11'h1e0}, '{16'h0080, 16'h7e40, 11'h081, 11'h05a}};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] regAddr, row_switch_interval, grayscale_clock_multiplier;
  logic [15:0] regWrData, regRdData, d;
  logic regWrite, regRead;
  logic [9:0] segment_clock_count;
  logic [4:0] red_smooth_step, green_smooth_step, blue_smooth_step, clockMultiple;
  logic [3:0] red_dim_boost, green_dim_boost, blue_dim_boost;
  logic [10:0] segmentClocks, rowSwitchClocks;
  logic [5:0] redStepLevel, greenStepLevel, blueStepLevel, black_field_trim;
  int err_count = 0;
  int total_checks = 0;
  led_cfg_host led_cfg_host_i (.mclk, .regAddr, .regWrData, .regWrite, .regRead, .regRdData);
  led_matrix_timing_config_reg led_matrix_timing_config_reg_i (.mclk, .rst, .regAddr,
    .regWrData, .regWrite, .regRead, .regRdData, .segment_clock_count, .red_smooth_step,
    .green_smooth_step, .blue_smooth_step, .red_dim_boost, .green_dim_boost,
    .blue_dim_boost, .row_switch_interval, .black_field_trim, .grayscale_clock_multiplier,
    .segmentClocks, .redStepLevel, .greenStepLevel, .blueStepLevel, .rowSwitchClocks,
    .clockMultiple);
  always #5 mclk = ~mclk;
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #50000;
    err_count++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk("rowClk", rowSwitchClocks, 11'h0f0);
    chk("step", redStepLevel, 6'h0a);
    chk("mult", clockMultiple, 5'h08);
    led_cfg_host_i.rd(led_cfg_pkg::ADDR_WORD0, d);
    chk("word0", d, 16'ha400);
    led_cfg_host_i.rd(led_cfg_pkg::ADDR_WORD1, d);
    chk("word1", d, 16'h0094);
    led_cfg_host_i.rd(led_cfg_pkg::ADDR_WORD2, d);
    chk("word2", d, 16'h00e0);
    $display("reset test done");
    foreach (rows[i]) begin
      led_cfg_host_i.wr(led_cfg_pkg::ADDR_WORD0, rows[i].w0);
      led_cfg_host_i.wr(led_cfg_pkg::ADDR_WORD2, rows[i].w2);
      repeat (2) @(posedge mclk);
      #1;
      chk("segClk", segmentClocks, rows[i].seg);
      chk("rowClk", rowSwitchClocks, rows[i].row);
      chk("step", redStepLevel, {1'b0, rows[i].w0[14:10]} + 6'h01);
      chk("bBoost", blue_dim_boost, rows[i].w2[4:1]);
      chk("trim", black_field_trim, rows[i].w2[14:9]);
      led_cfg_host_i.rd(led_cfg_pkg::ADDR_WORD2, d);
      chk("word2", d, rows[i].w2 & 16'h7fff);
    end
    $display("table test done");
    led_cfg_host_i.wr(led_cfg_pkg::ADDR_MULT, 16'hffff);
    led_cfg_host_i.wr(led_cfg_pkg::ADDR_WORD1, 16'h1a50);
    led_cfg_host_i.wr(led_cfg_pkg::ADDR_DERIVED0, 16'h0000);
    led_cfg_host_i.rd(led_cfg_pkg::ADDR_DERIVED0, d);
    chk("derived", d, 16'h0081);
    led_cfg_host_i.rd(4'hf, d);
    chk("unmapped", d, 16'h0000);
    chk("mult", clockMultiple, 5'h10);
    chk("bStep", blueStepLevel, 6'h06);
    chk("bStepRaw", blue_smooth_step, 5'h05);
    chk("gStep", greenStepLevel, 6'h01);
    chk("gStepRaw", green_smooth_step, 5'h00);
    chk("rBoost", red_dim_boost, 4'hd);
    chk("gBoost", green_dim_boost, 4'h0);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk("row", row_switch_interval, 4'h7);
    chk("segClk", segmentClocks, 11'h080);
    chk("rBoost", red_dim_boost, 4'h0);
    chk("bStep", blueStepLevel, 6'h0a);
    chk("mult", clockMultiple, 5'h08);
    $display("awkward test done");
    end_sim;
  end
endmodule
